/* File: rtl/asr_pkg.sv */
// Constants, types and error tables of the alarm status reporter.
package asr_pkg;

  // Timing.
  localparam int CLK_HZ        = 25_000_000;
  localparam int FAST_FLASH_HZ = 4;
  localparam int SLOW_FLASH_HZ = 1;
  localparam int RTC_TICK_HZ   = 1;
  localparam int FAST_HALF_CYC = CLK_HZ / (2 * FAST_FLASH_HZ);
  localparam int SLOW_HALF_CYC = CLK_HZ / (2 * SLOW_FLASH_HZ);
  localparam int RTC_TICK_CYC  = CLK_HZ / RTC_TICK_HZ;

  // Widths and history layout.
  localparam int ERR_W      = 10;
  localparam int MV_W       = 14;
  localparam int TS_W       = 32;
  localparam int HIST_DEPTH = 400;
  localparam int HIST_AW    = 9;
  localparam int CNT_W      = 10;
  localparam int ENTRY_W    = 2 + ERR_W + TS_W;
  localparam int ERR_LSB    = TS_W;
  localparam int TSV_BIT    = TS_W + ERR_W;
  localparam int KIND_BIT   = TS_W + ERR_W + 1;
  localparam int SYNC_N     = 3;

  // APB register byte offsets.
  localparam int        ADDR_W   = 8;
  localparam logic [7:0] A_CTRL   = 8'h00;
  localparam logic [7:0] A_STATUS = 8'h04;
  localparam logic [7:0] A_ERRNUM = 8'h08;
  localparam logic [7:0] A_RTC    = 8'h0C;
  localparam logic [7:0] A_RTCST  = 8'h10;
  localparam logic [7:0] A_HCOUNT = 8'h14;
  localparam logic [7:0] A_HIDX   = 8'h18;
  localparam logic [7:0] A_HLO    = 8'h1C;
  localparam logic [7:0] A_HHI    = 8'h20;
  localparam int         CTRL_INV_BIT = 0;

  // Analogue output codes in millivolts.
  localparam logic [MV_W-1:0] MV_ZERO = 14'h0000;
  localparam logic [MV_W-1:0] MV_FULL = 14'h2710;
  localparam logic [MV_W-1:0] LVL_MV [1:13] = '{
    14'h0294, 14'h0532, 14'h07D0, 14'h0A64, 14'h0D02, 14'h0FA0, 14'h1234,
    14'h14D2, 14'h1770, 14'h1A04, 14'h1CA2, 14'h1F40, 14'h21D4};

  // Error classes in rising priority; one-hot codes compare by value.
  typedef enum logic [3:0] {
    CLS_NONE = 4'b0001,
    CLS_CAL  = 4'b0010,
    CLS_CFG  = 4'b0100,
    CLS_MALF = 4'b1000
  } asr_cls_t;

  // Numbers not in the calibration or configuration groups stop start-up.
  function automatic asr_cls_t asr_err_class(input logic [ERR_W-1:0] n);
    if ((n >= 10'd104 && n <= 10'd106) || n == 10'd211 || n == 10'd302 || n == 10'd303)
      return CLS_CAL;
    if (n >= 10'd111 && n <= 10'd114)
      return CLS_CFG;
    return CLS_MALF;
  endfunction

  function automatic logic [MV_W-1:0] asr_err_level(input logic [ERR_W-1:0] n);
    if (n == 10'd101) return LVL_MV[1];
    if (n == 10'd102) return LVL_MV[2];
    if (n == 10'd103) return LVL_MV[3];
    if (n == 10'd107 || n == 10'd108 || (n >= 10'd307 && n <= 10'd310)) return LVL_MV[4];
    if (n >= 10'd201 && n <= 10'd203) return LVL_MV[5];
    if (n == 10'd304) return LVL_MV[6];
    if (n >= 10'd900 && n <= 10'd999) return LVL_MV[7];
    if (n >= 10'd104 && n <= 10'd106) return LVL_MV[8];
    if (n >= 10'd111 && n <= 10'd114) return LVL_MV[9];
    if (n == 10'd211) return LVL_MV[10];
    if (n == 10'd302) return LVL_MV[11];
    if (n == 10'd303) return LVL_MV[12];
    return LVL_MV[13];
  endfunction

endpackage

/* File: rtl/asr_div.sv */
// Free-running divider that emits a one-cycle tick every HALF_CYC cycles.
`timescale 1ns/1ns
`default_nettype none
module asr_div #(
  parameter int HALF_CYC = 2
) (
  // Clock and reset.
  input  wire logic pclk,
  input  wire logic presetn,
  // Tick.
  output logic      tick
);
  typedef struct packed {
    logic [31:0] cnt;
    logic        tick;
  } asr_div_t;

  asr_div_t st_reg;
  asr_div_t st_next;

  always_comb begin
    st_next = st_reg;
    st_next.tick = 1'b0;
    if (st_reg.cnt == 32'(HALF_CYC - 1)) begin
      st_next.cnt  = '0;
      st_next.tick = 1'b1;
    end else begin
      st_next.cnt = st_reg.cnt + 32'h0000_0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign tick = st_reg.tick;
endmodule // asr_div
`default_nettype wire

/* File: rtl/asr_hist_mem.sv */
// Message history storage with a registered read port.
`timescale 1ns/1ns
`default_nettype none
module asr_hist_mem (
  // Clock.
  input  wire logic                          pclk,
  // Write port.
  input  wire logic                          we,
  input  wire logic [asr_pkg::HIST_AW-1:0]   waddr,
  input  wire logic [asr_pkg::ENTRY_W-1:0]   wdata,
  // Read port.
  input  wire logic [asr_pkg::HIST_AW-1:0]   raddr,
  output logic      [asr_pkg::ENTRY_W-1:0]   rdata
);
  logic [asr_pkg::ENTRY_W-1:0] mem [asr_pkg::HIST_DEPTH];

  // No reset, so the array maps onto block RAM.
  always_ff @(posedge pclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule // asr_hist_mem
`default_nettype wire

/* File: rtl/asr_top.sv */
// Alarm classification, lamp, switch and analogue error output, history log.
//
// Notes on behaviour
// - Calibration-needed errors flash the alarm lamp at 4 Hz.
// - Configuration errors flash the alarm lamp at 1 Hz.
// - Blocking malfunctions light the alarm lamp continuously.
// - Calibration or configuration state: switch low, high only while start is active.
// - Blocking malfunction: switch high regardless of start.
// - Inverted polarity inverts every alarm switch state.
// - During alarm the analogue output carries one of 13 error levels.
// - Calibration or configuration state toggles output at 1 Hz with full scale.
// - Start active in those states stops toggling and holds the level.
// - Latched error clears on reset deassertion or power cycle, not while held.
// - History keeps the newest 400 messages, oldest overwritten, readable by software.
// - History records error messages and zero-calibration runs; a run signalled while another is pending shares its entry.
// - Each entry carries the real-time clock stamp at recording.
// - Unset or lost clock stores an invalid stamp marker; control continues.
// - Clock is set and read only through the software bus.
// - Detailed error number is readable by software.
// - Any alarm suppresses temperature indication on the analogue output.
// - Malfunction: constant level, lamp lit, alarm switch active.
// - Missing current 0.66 V, missing voltage 1.33 V, both 2.00 V.
`timescale 1ns/1ns
`default_nettype none
module asr_top #(
  parameter int FAST_HALF_CYC = asr_pkg::FAST_HALF_CYC,
  parameter int SLOW_HALF_CYC = asr_pkg::SLOW_HALF_CYC,
  parameter int RTC_TICK_CYC  = asr_pkg::RTC_TICK_CYC
) (
  // Clock and reset.
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  // APB slave.
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [asr_pkg::ADDR_W-1:0]  paddr,
  input  wire logic [31:0]                 pwdata,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  // Events from the controller core.
  input  wire logic                        err_valid,
  input  wire logic [asr_pkg::ERR_W-1:0]   err_num,
  input  wire logic                        auto_zero_calibration_done,
  // Pins.
  input  wire logic                        start_in,
  input  wire logic                        reset_in,
  input  wire logic                        clock_lost_in,
  // Alarm outputs.
  output logic                             alarm_led,
  output logic                             alarm_sw,
  output logic                             aout_alarm,
  output logic      [asr_pkg::MV_W-1:0]    aout_mv
);
  typedef struct packed {
    logic [asr_pkg::SYNC_N-1:0]  s_start;
    logic [asr_pkg::SYNC_N-1:0]  s_rst;
    logic [asr_pkg::SYNC_N-1:0]  s_lost;
    logic                        start_f;
    logic                        rst_f;
    logic                        lost_f;
    asr_pkg::asr_cls_t           cls;
    logic [asr_pkg::ERR_W-1:0]   errnum;
    logic                        fast_ph;
    logic                        slow_ph;
    logic                        inv;
    logic [asr_pkg::TS_W-1:0]    rtc;
    logic                        rtc_valid;
    logic [asr_pkg::HIST_AW-1:0] wr_ptr;
    logic [asr_pkg::CNT_W-1:0]   count;
    logic [asr_pkg::HIST_AW-1:0] idx;
    logic                        pend_cal;
    logic                        led;
    logic                        sw;
    logic                        aalarm;
    logic [asr_pkg::MV_W-1:0]    mv;
  } asr_state_t;

  asr_state_t st_reg;
  asr_state_t st_next;

  logic                          fast_tick;
  logic                          slow_tick;
  logic                          sec_tick;
  logic                          hist_we;
  logic [asr_pkg::ENTRY_W-1:0]   hist_wdata;
  logic [asr_pkg::HIST_AW-1:0]   hist_raddr;
  logic [asr_pkg::ENTRY_W-1:0]   hist_rdata;
  logic                          apb_wr;
  logic                          apb_acc;
  logic                          mapped;
  logic                          rst_fall;
  logic                          calcfg;
  asr_pkg::asr_cls_t             new_cls;
  logic [asr_pkg::MV_W-1:0]      lvl_mv;
  logic [asr_pkg::CNT_W-1:0]     rd_tmp;

  // One divider per rate; lamp and analogue output share the same phases.
  asr_div #(.HALF_CYC(FAST_HALF_CYC)) u_fast (
    .pclk(pclk), .presetn(presetn), .tick(fast_tick));
  asr_div #(.HALF_CYC(SLOW_HALF_CYC)) u_slow (
    .pclk(pclk), .presetn(presetn), .tick(slow_tick));
  asr_div #(.HALF_CYC(RTC_TICK_CYC)) u_sec (
    .pclk(pclk), .presetn(presetn), .tick(sec_tick));

  asr_hist_mem u_mem (
    .pclk (pclk),
    .we   (hist_we),
    .waddr(st_reg.wr_ptr),
    .wdata(hist_wdata),
    .raddr(hist_raddr),
    .rdata(hist_rdata)
  );

  assign apb_acc = psel && penable;
  assign apb_wr  = apb_acc && pwrite;
  assign new_cls = asr_pkg::asr_err_class(err_num);
  assign lvl_mv  = asr_pkg::asr_err_level(st_reg.errnum);
  assign calcfg  = (st_reg.cls == asr_pkg::CLS_CAL) || (st_reg.cls == asr_pkg::CLS_CFG);

  always_comb begin
    st_next    = st_reg;
    hist_we    = 1'b0;
    hist_wdata = '0;
    // Pins: a change counts once the second and third stages agree.
    st_next.s_start = {st_reg.s_start[1:0], start_in};
    st_next.s_rst   = {st_reg.s_rst[1:0], reset_in};
    st_next.s_lost  = {st_reg.s_lost[1:0], clock_lost_in};
    if (st_reg.s_start[1] == st_reg.s_start[2]) begin
      st_next.start_f = st_reg.s_start[2];
    end
    if (st_reg.s_rst[1] == st_reg.s_rst[2]) begin
      st_next.rst_f = st_reg.s_rst[2];
    end
    if (st_reg.s_lost[1] == st_reg.s_lost[2]) begin
      st_next.lost_f = st_reg.s_lost[2];
    end
    rst_fall = st_reg.rst_f && !st_next.rst_f;
    // Clear on release of the reset pin; an error in that cycle still latches.
    if (rst_fall) begin
      st_next.cls    = asr_pkg::CLS_NONE;
      st_next.errnum = '0;
    end
    if (err_valid && (new_cls >= st_next.cls)) begin
      st_next.cls    = new_cls;
      st_next.errnum = err_num;
    end
    if (fast_tick) begin
      st_next.fast_ph = !st_reg.fast_ph;
    end
    if (slow_tick) begin
      st_next.slow_ph = !st_reg.slow_ph;
    end
    // Real-time clock; a software write sets it and wins over a loss.
    if (sec_tick) begin
      st_next.rtc = st_reg.rtc + 32'h0000_0001;
    end
    if (st_reg.lost_f) begin
      st_next.rtc_valid = 1'b0;
    end
    if (apb_wr && paddr == asr_pkg::A_RTC) begin
      st_next.rtc       = pwdata;
      st_next.rtc_valid = 1'b1;
    end
    if (apb_wr && paddr == asr_pkg::A_CTRL) begin
      st_next.inv = pwdata[asr_pkg::CTRL_INV_BIT];
    end
    if (apb_wr && paddr == asr_pkg::A_HIDX) begin
      st_next.idx = pwdata[asr_pkg::HIST_AW-1:0];
    end
    // History: an error entry goes first, a calibration run waits one slot.
    if (err_valid) begin
      hist_we    = 1'b1;
      hist_wdata = {1'b0, st_reg.rtc_valid, err_num, st_reg.rtc};
      st_next.pend_cal = st_reg.pend_cal || auto_zero_calibration_done;
    end else if (st_reg.pend_cal || auto_zero_calibration_done) begin
      hist_we    = 1'b1;
      hist_wdata = {1'b1, st_reg.rtc_valid, {asr_pkg::ERR_W{1'b0}}, st_reg.rtc};
      st_next.pend_cal = 1'b0;
    end
    if (hist_we) begin
      if (st_reg.wr_ptr == asr_pkg::HIST_AW'(asr_pkg::HIST_DEPTH - 1)) begin
        st_next.wr_ptr = '0;
      end else begin
        st_next.wr_ptr = st_reg.wr_ptr + 9'h001;
      end
      if (st_reg.count != asr_pkg::CNT_W'(asr_pkg::HIST_DEPTH)) begin
        st_next.count = st_reg.count + 10'h001;
      end
    end
    // Lamp.
    case (st_reg.cls)
      asr_pkg::CLS_MALF: st_next.led = 1'b1;
      asr_pkg::CLS_CFG:  st_next.led = st_reg.slow_ph;
      asr_pkg::CLS_CAL:  st_next.led = st_reg.fast_ph;
      asr_pkg::CLS_NONE: st_next.led = 1'b0;
      default:           st_next.led = 1'b0;
    endcase
    // Alarm switch.
    st_next.sw = ((st_reg.cls == asr_pkg::CLS_MALF)
                 || (calcfg && st_reg.start_f))
                 ^ st_reg.inv;
    // Analogue output replaces temperature while any alarm is latched.
    st_next.aalarm = (st_reg.cls != asr_pkg::CLS_NONE);
    if (st_reg.cls == asr_pkg::CLS_NONE) begin
      st_next.mv = asr_pkg::MV_ZERO;
    end else if (calcfg && !st_reg.start_f && st_reg.slow_ph) begin
      st_next.mv = asr_pkg::MV_FULL;
    end else begin
      st_next.mv = lvl_mv;
    end
  end

  // Newest entry at index 0.
  always_comb begin
    rd_tmp = CNT_ADD(st_reg.wr_ptr, st_reg.idx);
    if (rd_tmp >= asr_pkg::CNT_W'(asr_pkg::HIST_DEPTH)) begin
      rd_tmp = rd_tmp - asr_pkg::CNT_W'(asr_pkg::HIST_DEPTH);
    end
    hist_raddr = rd_tmp[asr_pkg::HIST_AW-1:0];
  end

  function automatic logic [asr_pkg::CNT_W-1:0] CNT_ADD(
      input logic [asr_pkg::HIST_AW-1:0] p, input logic [asr_pkg::HIST_AW-1:0] i);
    return {1'b0, p} + asr_pkg::CNT_W'(asr_pkg::HIST_DEPTH - 1) - {1'b0, i};
  endfunction

  // Read decode; every register answers with no wait state.
  always_comb begin
    mapped = 1'b1;
    prdata = '0;
    case (paddr)
      asr_pkg::A_CTRL:   prdata[asr_pkg::CTRL_INV_BIT] = st_reg.inv;
      asr_pkg::A_STATUS: prdata[3:0] = st_reg.cls;
      asr_pkg::A_ERRNUM: prdata[asr_pkg::ERR_W-1:0] = st_reg.errnum;
      asr_pkg::A_RTC:    prdata = st_reg.rtc;
      asr_pkg::A_RTCST:  prdata[0] = st_reg.rtc_valid;
      asr_pkg::A_HCOUNT: prdata[asr_pkg::CNT_W-1:0] = st_reg.count;
      asr_pkg::A_HIDX:   prdata[asr_pkg::HIST_AW-1:0] = st_reg.idx;
      asr_pkg::A_HLO: begin
        if ({1'b0, st_reg.idx} < st_reg.count) begin
          prdata = hist_rdata[asr_pkg::TS_W-1:0];
        end
      end
      asr_pkg::A_HHI: begin
        if ({1'b0, st_reg.idx} < st_reg.count) begin
          prdata[asr_pkg::ENTRY_W-asr_pkg::TS_W-1:0] =
            hist_rdata[asr_pkg::ENTRY_W-1:asr_pkg::ERR_LSB];
        end
      end
      default: mapped = 1'b0;
    endcase
  end

  assign pready  = 1'b1;
  assign pslverr = apb_acc && !mapped;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg     <= '0;
      st_reg.cls <= asr_pkg::CLS_NONE;
    end else begin
      st_reg <= st_next;
    end
  end

  assign alarm_led  = st_reg.led;
  assign alarm_sw   = st_reg.sw;
  assign aout_alarm = st_reg.aalarm;
  assign aout_mv    = st_reg.mv;

  // Checks.
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_fast_flash: assert property (st_reg.cls == asr_pkg::CLS_CAL
    |=> alarm_led == $past(st_reg.fast_ph)) else $error("calibration lamp not on fast phase");
  a_slow_flash: assert property (st_reg.cls == asr_pkg::CLS_CFG
    |=> alarm_led == $past(st_reg.slow_ph)) else $error("config lamp not on slow phase");
  a_malf_lamp: assert property (st_reg.cls == asr_pkg::CLS_MALF
    |=> alarm_led && aout_alarm) else $error("malfunction lamp not lit");
  a_sw_start: assert property (calcfg
    |=> alarm_sw == ($past(st_reg.start_f) ^ $past(st_reg.inv))) else $error("switch wrong");
  a_sw_malf: assert property (st_reg.cls == asr_pkg::CLS_MALF
    |=> alarm_sw != $past(st_reg.inv)) else $error("malfunction switch wrong");
  a_sw_idle: assert property (st_reg.cls == asr_pkg::CLS_NONE
    |=> alarm_sw == $past(st_reg.inv)) else $error("idle switch wrong");
  a_aout_toggle: assert property (calcfg && !st_reg.start_f && st_reg.slow_ph
    |=> aout_mv == asr_pkg::MV_FULL) else $error("full scale phase missing");
  a_aout_hold: assert property (calcfg && st_reg.start_f
    |=> aout_mv == $past(lvl_mv)) else $error("level not held under start");
  a_reset_clear: assert property (rst_fall && !err_valid
    |=> st_reg.cls == asr_pkg::CLS_NONE ##1 !aout_alarm) else $error("reset did not clear");
  a_reset_hold: assert property (st_reg.rst_f && st_reg.s_rst[1] && st_reg.s_rst[2]
    && st_reg.cls != asr_pkg::CLS_NONE |=> st_reg.cls != asr_pkg::CLS_NONE)
    else $error("error cleared while reset held");
  a_hist_bound: assert property (st_reg.count <= asr_pkg::CNT_W'(asr_pkg::HIST_DEPTH))
    else $error("history count over depth");
  a_ts_marker: assert property (hist_we && !st_reg.rtc_valid
    |-> !hist_wdata[asr_pkg::TSV_BIT]) else $error("invalid stamp marked valid");
  a_priority: assert property (st_reg.cls == asr_pkg::CLS_MALF && !rst_fall
    |=> st_reg.cls == asr_pkg::CLS_MALF) else $error("malfunction class lost");

  c_cal:   cover property (st_reg.cls == asr_pkg::CLS_CAL && fast_tick);
  c_cfg:   cover property (st_reg.cls == asr_pkg::CLS_CFG && st_reg.start_f);
  c_malf:  cover property (st_reg.cls == asr_pkg::CLS_MALF ##1 rst_fall);
  c_full:  cover property (hist_we && st_reg.count == asr_pkg::CNT_W'(asr_pkg::HIST_DEPTH));
endmodule // asr_top
`default_nettype wire

/* File: test/asr_plc_model.sv */
// Supervising controller model that decodes the analogue error output.
`timescale 1ns/1ns
`default_nettype none
module asr_plc_model (
  // Observed outputs.
  input  wire logic        aout_alarm,
  input  wire logic [13:0] aout_mv,
  // Decoded level, 0 with no alarm, 15 at full scale.
  output logic      [3:0]  plc_lvl
);
  int mv;

  // Rounding to the nearest 667 mV step gives a window of about a third of a volt per side.
  // Narrower windows would misclassify codes within the output tolerance.
  always_comb begin
    mv = int'(aout_mv);
    plc_lvl = aout_alarm ? 4'((mv + 333) / 667) : 4'h0;
  end
endmodule // asr_plc_model
`default_nettype wire

/* File: test/tb_alarm_status_reporter.sv */
// Self-checking bench for the alarm status reporter.
`timescale 1ns/1ns
`default_nettype none
module tb_alarm_status_reporter;
  localparam int FH = 4;
  localparam int SH = 16;
  logic        pclk = 0;
  logic        presetn = 0;
  logic        psel = 0;
  logic        penable = 0;
  logic        pwrite = 0;
  logic [7:0]  paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        err_valid = 0;
  logic [9:0]  err_num = '0;
  logic        azc = 0;
  logic        start_in = 0;
  logic        reset_in = 0;
  logic        lost = 0;
  logic        alarm_led;
  logic        alarm_sw;
  logic        aout_alarm;
  logic [13:0] aout_mv;
  logic [3:0]  plc_lvl;
  logic [31:0] r;
  logic        serr;
  int error_cnt = 0;
  int total_checks = 0;
  int cyc = 0;
  int seed = 83625;
  int hq[$];
  int tl;
  int ta;
  int n;
  int codes[7] = '{101, 102, 103, 107, 201, 304, 901};
  int lvls[7] = '{660, 1330, 2000, 2660, 3330, 4000, 4660};

  asr_top #(.FAST_HALF_CYC(FH), .SLOW_HALF_CYC(SH), .RTC_TICK_CYC(8)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .err_valid(err_valid), .err_num(err_num), .auto_zero_calibration_done(azc),
    .start_in(start_in), .reset_in(reset_in), .clock_lost_in(lost),
    .alarm_led(alarm_led), .alarm_sw(alarm_sw), .aout_alarm(aout_alarm), .aout_mv(aout_mv));

  asr_plc_model plc (.aout_alarm(aout_alarm), .aout_mv(aout_mv), .plc_lvl(plc_lvl));

  always #20 pclk = ~pclk;

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Hangs end here rather than in each wait loop.
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      tally_and_finish();
    end
  end

  task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %0h seen %0h", s, exp, seen);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    serr = pslverr;
    psel <= 0;
    penable <= 0;
  endtask

  task automatic ev(input int c, input int tsv);
    @(posedge pclk);
    err_valid <= 1;
    err_num <= 10'(c);
    @(posedge pclk);
    err_valid <= 0;
    hq.push_front((tsv << 10) | c);
  endtask

  // Counts lamp and analogue changes over two slow half periods.
  task automatic watch();
    logic l;
    logic [13:0] m;
    tl = 0;
    ta = 0;
    // Long enough for a start change to pass the pin synchroniser and the output register.
    repeat (6) @(posedge pclk);
    @(negedge pclk);
    l = alarm_led;
    m = aout_mv;
    repeat (2 * SH) begin
      @(negedge pclk);
      tl += (alarm_led !== l);
      ta += (aout_mv !== m);
      l = alarm_led;
      m = aout_mv;
    end
  endtask

  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1;
    apb(0, asr_pkg::A_STATUS, 0);
    chk("status", r, 1);
    apb(0, asr_pkg::A_HCOUNT, 0);
    chk("hcount", r, 0);
    apb(0, asr_pkg::A_HLO, 0);
    chk("empty_lo", r, 0);
    apb(0, 8'h40, 0);
    chk("unmapped", serr, 1);
    apb(0, asr_pkg::A_RTCST, 0);
    chk("rtc_valid", r, 0);
    ev(104, 0);
    watch();
    chk("cal_led", tl, 2 * SH / FH);
    chk("cal_aout", ta, 2);
    chk("cal_sw", alarm_sw, 0);
    chk("cal_alarm", aout_alarm, 1);
    apb(0, asr_pkg::A_ERRNUM, 0);
    chk("errnum", r, 104);
    start_in <= 1;
    watch();
    chk("start_sw", alarm_sw, 1);
    chk("start_aout", ta, 0);
    chk("start_mv", aout_mv, 5330);
    chk("plc", plc_lvl, 8);
    @(posedge pclk);
    start_in <= 0;
    ev(112, 0);
    ev(104, 0);
    watch();
    chk("cfg_led", tl, 2);
    chk("cfg_aout", ta, 2);
    apb(0, asr_pkg::A_STATUS, 0);
    chk("cfg_status", r, 4);
    apb(0, asr_pkg::A_HHI, 0);
    chk("hist_tsv", r, hq[0]);
    @(posedge pclk);
    azc <= 1;
    @(posedge pclk);
    azc <= 0;
    hq.push_front(32'h0000_0800);
    apb(0, asr_pkg::A_HHI, 0);
    chk("cal_kind", r, hq[0]);
    // An error and a calibration run in one cycle: the run is logged one slot later.
    @(posedge pclk);
    err_valid <= 1;
    err_num <= 10'd105;
    azc <= 1;
    @(posedge pclk);
    err_valid <= 0;
    azc <= 0;
    hq.push_front(105);
    hq.push_front(32'h0000_0800);
    apb(0, asr_pkg::A_HHI, 0);
    chk("pend_cal", r, hq[0]);
    apb(1, asr_pkg::A_HIDX, 1);
    apb(0, asr_pkg::A_HHI, 0);
    chk("pend_err", r, hq[1]);
    ev(101, 0);
    watch();
    chk("malf_led", tl, 0);
    chk("malf_lamp", alarm_led, 1);
    chk("malf_sw", alarm_sw, 1);
    chk("malf_hold", ta, 0);
    chk("malf_mv", aout_mv, 660);
    chk("malf_plc", plc_lvl, 1);
    apb(1, asr_pkg::A_CTRL, 1);
    repeat (2) @(posedge pclk);
    chk("inv_sw", alarm_sw, 0);
    apb(1, asr_pkg::A_CTRL, 0);
    reset_in <= 1;
    repeat (8) @(posedge pclk);
    chk("held", aout_alarm, 1);
    reset_in <= 0;
    repeat (8) @(posedge pclk);
    chk("cleared", {aout_alarm, aout_mv}, 0);
    apb(1, asr_pkg::A_RTC, 32'h0000_1000);
    apb(0, asr_pkg::A_RTCST, 0);
    chk("rtc_set", r, 1);
    apb(0, asr_pkg::A_RTC, 0);
    chk("rtc_read", r >= 32'h1000 && r < 32'h1002, 1);
    lost <= 1;
    repeat (6) @(posedge pclk);
    lost <= 0;
    apb(0, asr_pkg::A_RTCST, 0);
    chk("rtc_lost", r, 0);
    apb(1, asr_pkg::A_RTC, 32'h0000_1000);
    repeat (405) begin
      n = ($random(seed) & 32'h7fff_ffff) % 7;
      ev(codes[n], 1);
    end
    repeat (3) @(posedge pclk);
    chk("last_mv", aout_mv, lvls[n]);
    apb(0, asr_pkg::A_HCOUNT, 0);
    chk("full", r, 400);
    foreach (lvls[i]) begin
      apb(1, asr_pkg::A_HIDX, i * 66);
      apb(0, asr_pkg::A_HHI, 0);
      chk("hist", r, hq[i * 66]);
    end
    apb(0, asr_pkg::A_HLO, 0);
    chk("stamp", r >= 32'h1000 && r < 32'h1200, 1);
    tally_and_finish();
  end
endmodule // tb_alarm_status_reporter
`default_nettype wire
